// ---- hdl/srs_pkg.sv ----
// package: constants for the stop release and reset sequencer
package srs_pkg;
	// reset values
	localparam logic [7:0] SRS_PSW_RST = 8'h02;
	localparam logic [7:0] SRS_PORT_LATCH_RST = 8'h00;
	localparam logic [7:0] SRS_PORT_DIR_RST = 8'hFF;
	localparam logic [7:0] SRS_SETTLE_SEL_RST = 8'h04;
	localparam logic [7:0] SRS_IRQ_REQ_RST = 8'h00;
	localparam logic [7:0] SRS_IRQ_MASK_RST = 8'hFF;
	localparam logic [7:0] SRS_EDGE_RST = 8'h00;
	localparam logic [7:0] SRS_TX_SHIFT_RST = 8'hFF;
	// reset vector location
	localparam logic [15:0] SRS_VEC_LO_ADDR = 16'h0000;
	localparam logic [15:0] SRS_VEC_HI_ADDR = 16'h0001;
	// settle select codes and exponents
	localparam logic [2:0] SRS_SEL_12 = 3'h0;
	localparam logic [2:0] SRS_SEL_15 = 3'h2;
	localparam logic [2:0] SRS_SEL_17 = 3'h4;
	localparam int SRS_EXP_12 = 12;
	localparam int SRS_EXP_15 = 15;
	localparam int SRS_EXP_17 = 17;
	localparam int SRS_CNT_W = 18;
	// least reset pin low time
	localparam int SRS_CLK_NS = 25;
	localparam int SRS_PIN_LOW_MIN_NS = 10000;
	localparam int SRS_PIN_LOW_CYC =
		(SRS_PIN_LOW_MIN_NS + SRS_CLK_NS - 1) / SRS_CLK_NS;
	typedef enum logic [2:0] {
		SRS_RUN,
		SRS_STOP,
		SRS_RESET,
		SRS_SETTLE,
		SRS_VEC_LO,
		SRS_VEC_HI
	} srs_state_type;
endpackage : srs_pkg

// ---- hdl/srs_settle_cnt.sv ----
// settle counter: counts oscillator cycles once oscillation runs
`timescale 1ns/1ps
module srs_settle_cnt
	import srs_pkg::*;
#(
	parameter int CNT_W = SRS_CNT_W
)(
	input wire logic clk_sys_i, // system clock
	input wire logic rst_i, // sync reset
	input wire logic start_i, // load and begin
	input wire logic osc_run_i, // oscillator running
	input wire logic [CNT_W-1:0] limit_i, // terminal count
	output logic done_o // one-cycle terminal pulse
);
	logic [CNT_W-1:0] cnt_reg;
	logic busy_reg;
	wire at_end = busy_reg && osc_run_i && (cnt_reg == limit_i - 1'b1);

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || start_i)
		begin
			cnt_reg <= '0;
			busy_reg <= start_i;
			done_o <= 1'b0;
		end
		else
		begin
			if (busy_reg && osc_run_i)
				cnt_reg <= cnt_reg + 1'b1;
			if (at_end)
				busy_reg <= 1'b0;
			done_o <= at_end;
		end
	end
endmodule : srs_settle_cnt

// ---- hdl/srs_sequencer.sv ----
// stop release and reset sequencer top
//
// Operation
// - unmasked request ends stop; vectored service only after settling ends
// - with interrupts disabled, wake resumes at instruction after stop
// - mask 0 wakes; enable picks service or next; mask 1 stays; reset resets
// - reset pin during stop resets at once; execution starts only after settling ends
// - pin reset and watchdog overflow both reset; watchdog settle follows settle select, pin reset settle is 2^15
// - after reset, program counter loads two-byte vector at 0000H/0001H
// - all pins high impedance during reset and following settle interval
// - high reset pin clears reset; execution starts after settling
// - watchdog reset clears itself; execution resumes after settling
// - reset from stop keeps stop contents; ports still go high impedance
// - program counter undefined during reset and settle; rest already reset
// - memory undefined after power-up; held when reset from standby
// - reset sets status word 02H, latches 00H, directions FFH
// - reset loads settle time select with 04H
// - request and edge regs cleared; masks set to FFH
// - reset loads serial transmit shift register with ones
// - settle after pin reset is fixed at 2^15 cycles
// - settle count starts only once oscillation begins
`timescale 1ns/1ps
module srs_sequencer
	import srs_pkg::*;
#(
	parameter int N_IRQ = 8,
	parameter int CNT_W = SRS_CNT_W
)(
	input wire logic clk_sys_i, // system clock
	input wire logic rst_i, // sync reset, power-up
	input wire logic reset_pin_n_i, // external reset pin, active low
	input wire logic wdt_ovf_i, // watchdog overflow pulse
	input wire logic osc_run_i, // oscillator running
	input wire logic stop_cmd_i, // cpu executes stop
	input wire logic [N_IRQ-1:0] irq_flag_i, // interrupt request flags
	input wire logic [N_IRQ-1:0] irq_mask_i, // interrupt mask flags
	input wire logic accept_en_i, // interrupt accept enable
	input wire logic [2:0] settle_sel_i, // settle time select
	input wire logic [7:0] vec_data_i, // program memory read data
	output logic [15:0] vec_addr_o, // vector fetch address
	output logic vec_rd_o, // vector fetch strobe
	output logic [15:0] pc_o, // loaded program counter
	output logic pc_load_o, // pc valid pulse
	output logic cpu_clk_en_o, // cpu clock enable
	output logic osc_stop_o, // stop oscillator
	output logic pins_oe_n_o, // pin output enable, low drives
	output logic periph_rst_o, // peripheral reset to post-reset values
	output logic mem_hold_o, // memory hold during standby reset
	output logic resume_next_o, // resume at next instruction pulse
	output logic irq_service_o, // begin vectored service pulse
	output logic [7:0] psw_o, // program status word reset value
	output logic [7:0] port_latch_o, // port output latch reset value
	output logic [7:0] port_dir_o, // port direction reset value
	output logic [7:0] settle_sel_o, // settle select reset value
	output logic [7:0] irq_req_o, // request flag reset value
	output logic [7:0] irq_mask_o, // mask flag reset value
	output logic [7:0] edge_mode_o, // edge mode reset value
	output logic [7:0] tx_shift_o // serial shift reset value
);
	srs_state_type state_reg, state_next;
	logic from_stop_reg; // settle follows a stop wake
	logic was_reset_reg; // settle follows a reset
	logic accept_reg; // enable captured at wake
	logic pin_reset_reg; // settle length fixed for pin reset
	logic [7:0] vec_lo_reg;
	logic [CNT_W-1:0] limit;
	logic settle_done;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// mask gating
	wire wake_req = |(irq_flag_i & ~irq_mask_i);
	wire reset_src = !reset_pin_n_i || wdt_ovf_i;
	wire in_reset = (state_reg == SRS_RESET);
	wire reset_clear = in_reset && reset_pin_n_i;
	wire wake = (state_reg == SRS_STOP) && wake_req && !reset_src;
	wire start_settle = reset_clear || wake;
	wire [2:0] sel_eff = pin_reset_reg ? SRS_SEL_15 : settle_sel_i;
	assign limit = (sel_eff == SRS_SEL_12) ?
		CNT_W'(1 << SRS_EXP_12) :
		(sel_eff == SRS_SEL_15) ? CNT_W'(1 << SRS_EXP_15) :
		CNT_W'(1 << SRS_EXP_17);

	srs_settle_cnt #(
		.CNT_W(CNT_W)
	) u_settle (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.start_i(start_settle),
		.osc_run_i(osc_run_i),
		.limit_i(limit),
		.done_o(settle_done)
	);

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			SRS_RUN:
				if (reset_src)
					state_next = SRS_RESET;
				else if (stop_cmd_i)
					state_next = SRS_STOP;
			SRS_STOP:
				if (reset_src)
					state_next = SRS_RESET;
				else if (wake_req)
					state_next = SRS_SETTLE;
			SRS_RESET:
				if (reset_pin_n_i)
					state_next = SRS_SETTLE;
			SRS_SETTLE:
				if (!reset_pin_n_i)
					state_next = SRS_RESET;
				else if (settle_done)
					state_next = was_reset_reg ? SRS_VEC_LO : SRS_RUN;
			SRS_VEC_LO:
				state_next = SRS_VEC_HI;
			SRS_VEC_HI:
				state_next = SRS_RUN;
		endcase
	end

	wire to_reset = (state_next == SRS_RESET) && !in_reset;
	wire vec_done = (state_reg == SRS_VEC_HI);
	wire wake_done = (state_reg == SRS_SETTLE) && settle_done &&
		!was_reset_reg && reset_pin_n_i;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			state_reg <= SRS_RESET;
			from_stop_reg <= 1'b0;
			was_reset_reg <= 1'b1;
			accept_reg <= 1'b0;
			pin_reset_reg <= 1'b1;
			vec_lo_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			if (to_reset)
			begin
				was_reset_reg <= 1'b1;
				pin_reset_reg <= !reset_pin_n_i;
			end
			if (in_reset && !reset_pin_n_i)
				pin_reset_reg <= 1'b1;
			if (wake)
			begin
				from_stop_reg <= 1'b1;
				was_reset_reg <= 1'b0;
				pin_reset_reg <= 1'b0;
				accept_reg <= accept_en_i;
			end
			if (vec_done || wake_done)
				from_stop_reg <= 1'b0;
			if (state_reg == SRS_VEC_HI)
				pin_reset_reg <= 1'b0;
			if (state_reg == SRS_VEC_LO)
				vec_lo_reg <= vec_data_i;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			vec_addr_o <= SRS_VEC_LO_ADDR;
			vec_rd_o <= 1'b0;
			pc_o <= 16'h0000;
			pc_load_o <= 1'b0;
			cpu_clk_en_o <= 1'b0;
			osc_stop_o <= 1'b0;
			pins_oe_n_o <= 1'b1;
			periph_rst_o <= 1'b1;
			mem_hold_o <= 1'b0;
			resume_next_o <= 1'b0;
			irq_service_o <= 1'b0;
		end
		else
		begin
			vec_rd_o <= (state_next == SRS_VEC_LO) ||
				(state_next == SRS_VEC_HI);
			vec_addr_o <= (state_next == SRS_VEC_HI) ?
				SRS_VEC_HI_ADDR : SRS_VEC_LO_ADDR;
			pc_load_o <= vec_done;
			if (vec_done)
				pc_o <= {vec_data_i, vec_lo_reg};
			cpu_clk_en_o <= (state_next == SRS_RUN);
			// oscillator stays off while a reset taken from stop is held
			osc_stop_o <= (state_next == SRS_STOP) ||
				((state_next == SRS_RESET) &&
				(mem_hold_o || (state_reg == SRS_STOP)));
			pins_oe_n_o <= (state_next == SRS_RESET) ||
				(state_next == SRS_SETTLE && was_reset_reg && !wake) ||
				(state_next == SRS_SETTLE && !wake && !from_stop_reg) ||
				(state_next == SRS_VEC_LO) || (state_next == SRS_VEC_HI);
			periph_rst_o <= (state_next == SRS_RESET) ||
				((state_next == SRS_SETTLE) && ((was_reset_reg && !wake) ||
				to_reset || reset_clear)) || (state_next == SRS_VEC_LO) ||
				(state_next == SRS_VEC_HI);
			if (to_reset)
				mem_hold_o <= (state_reg == SRS_STOP);
			else if (vec_done)
				mem_hold_o <= 1'b0;
			resume_next_o <= wake_done && !accept_reg;
			irq_service_o <= wake_done && accept_reg;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		psw_o <= SRS_PSW_RST;
		port_latch_o <= SRS_PORT_LATCH_RST;
		port_dir_o <= SRS_PORT_DIR_RST;
		settle_sel_o <= SRS_SETTLE_SEL_RST;
		irq_req_o <= SRS_IRQ_REQ_RST;
		irq_mask_o <= SRS_IRQ_MASK_RST;
		edge_mode_o <= SRS_EDGE_RST;
		tx_shift_o <= SRS_TX_SHIFT_RST;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_masked_stays;
		@(posedge clk_sys_i) disable iff (rst_i)
		(state_reg == SRS_STOP && !wake_req && !reset_src && !stop_cmd_i)
		|=> (state_reg == SRS_STOP);
	endproperty
	a_masked_stays: assert property (p_masked_stays)
		else $error("masked request left stop");

	property p_wake_settle;
		@(posedge clk_sys_i) disable iff (rst_i)
		wake |=> (state_reg == SRS_SETTLE) && !cpu_clk_en_o;
	endproperty
	a_wake_settle: assert property (p_wake_settle)
		else $error("wake did not enter settle");

	property p_service_gated;
		@(posedge clk_sys_i) disable iff (rst_i)
		resume_next_o |-> !irq_service_o && $past(state_reg) == SRS_SETTLE;
	endproperty
	a_service_gated: assert property (p_service_gated)
		else $error("resume without settle");

	property p_reset_hiz;
		@(posedge clk_sys_i) disable iff (rst_i)
		(state_reg == SRS_RESET) |=> pins_oe_n_o;
	endproperty
	a_reset_hiz: assert property (p_reset_hiz)
		else $error("pins driven in reset");

	property p_wdt_reset;
		@(posedge clk_sys_i) disable iff (rst_i)
		(wdt_ovf_i && state_reg == SRS_RUN) |=> state_reg == SRS_RESET;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset)
		else $error("watchdog did not reset");

	sequence s_vec_fetch;
		state_reg == SRS_VEC_LO ##1 state_reg == SRS_VEC_HI;
	endsequence
	property p_vector;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_vec_fetch |=> pc_load_o && pc_o == {$past(vec_data_i),
			vec_lo_reg};
	endproperty
	a_vector: assert property (p_vector)
		else $error("pc not loaded from vector");

	property p_release_same;
		@(posedge clk_sys_i) disable iff (rst_i)
		wake_done |=> cpu_clk_en_o;
	endproperty
	a_release_same: assert property (p_release_same)
		else $error("cpu not released at terminal");

	property p_pin_settle;
		@(posedge clk_sys_i) disable iff (rst_i)
		(state_reg == SRS_SETTLE && pin_reset_reg)
		|-> limit == CNT_W'(1 << SRS_EXP_15);
	endproperty
	a_pin_settle: assert property (p_pin_settle)
		else $error("pin reset settle not 2^15");
endmodule : srs_sequencer

// ---- test/srs_partner.sv ----
// partner: reset pin, watchdog, request flags, oscillator, vector rom
`timescale 1ns/1ps
module srs_partner
	import srs_pkg::*;
#(
	parameter int N_IRQ = 8,
	parameter int OSC_START = 20,
	parameter logic [15:0] VEC_WORD = 16'h1A5C // arbitrary
)(
	input wire logic clk_sys_i, // system clock
	input wire logic osc_stop_i, // oscillator stop
	input wire logic [15:0] vec_addr_i, // fetch address
	input wire logic vec_rd_i, // fetch strobe
	output logic reset_pin_n_o, // reset pin
	output logic wdt_ovf_o, // watchdog overflow
	output logic osc_run_o, // oscillator running
	output logic [N_IRQ-1:0] irq_flag_o, // request flags
	output logic [7:0] vec_data_o // rom data
);
	logic [7:0] start_reg = 8'h00;
	logic [7:0] junk_reg = 8'h00;
	initial
	begin
		reset_pin_n_o = 1'b1;
		wdt_ovf_o = 1'b0;
		irq_flag_o = '0;
	end
	always @(posedge clk_sys_i)
	begin
		junk_reg <= junk_reg + 8'h3B;
		if (osc_stop_i === 1'b1)
			start_reg <= 8'(OSC_START);
		else if (start_reg != 8'h00)
			start_reg <= start_reg - 8'h01;
	end
	assign osc_run_o = osc_stop_i === 1'b0 && start_reg == 8'h00;
	// off-strobe data churns so a stale byte never passes
	assign vec_data_o = !vec_rd_i ? junk_reg :
		vec_addr_i == 16'h0000 ? VEC_WORD[7:0] :
		vec_addr_i == 16'h0001 ? VEC_WORD[15:8] : ~junk_reg;
	task automatic pin_reset(input int cycles);
	begin
		reset_pin_n_o = 1'b0;
		repeat (cycles) @(posedge clk_sys_i);
		#2;
		reset_pin_n_o = 1'b1;
	end
	endtask : pin_reset
	task automatic wdt_pulse;
	begin
		wdt_ovf_o = 1'b1;
		@(posedge clk_sys_i);
		#2;
		wdt_ovf_o = 1'b0;
	end
	endtask : wdt_pulse
	task automatic set_flags(input logic [N_IRQ-1:0] f);
	begin
		irq_flag_o = f;
	end
	endtask : set_flags
endmodule : srs_partner

// ---- test/srs_sequencer_tb.sv ----
// testbench for the stop release and reset sequencer
`timescale 1ns/1ps
module srs_sequencer_tb
	import srs_pkg::*;
	;
	localparam int OSC_START = 20;
	localparam logic [15:0] VEC_WORD = 16'h1A5C;
	localparam int LIM15 = 32768;
	localparam int LIM12 = 4096;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic stop_cmd_i = 1'b0;
	logic accept_en_i = 1'b0;
	logic [7:0] irq_mask_i = 8'hFF;
	logic [2:0] settle_sel_i = 3'h0;
	logic reset_pin_n_i, wdt_ovf_i, osc_run_i;
	logic [7:0] irq_flag_i, vec_data_i;
	logic [15:0] vec_addr_o, pc_o;
	logic vec_rd_o, pc_load_o, cpu_clk_en_o, osc_stop_o, pins_oe_n_o;
	logic periph_rst_o, mem_hold_o, resume_next_o, irq_service_o;
	logic [7:0] psw_o, port_latch_o, port_dir_o, settle_sel_o;
	logic [7:0] irq_req_o, irq_mask_o, edge_mode_o, tx_shift_o;
	int num_errors = 0;
	int n_tests = 0;
	int n_cyc, n_srv, n_nxt, n_pcl, n_drv, n_rst;
	always #12.5 clk_sys_i = ~clk_sys_i;
	srs_sequencer #(.N_IRQ(8)) u_srs_sequencer (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i), .wdt_ovf_i(wdt_ovf_i),
		.osc_run_i(osc_run_i), .stop_cmd_i(stop_cmd_i),
		.irq_flag_i(irq_flag_i), .irq_mask_i(irq_mask_i),
		.accept_en_i(accept_en_i), .settle_sel_i(settle_sel_i),
		.vec_data_i(vec_data_i), .vec_addr_o(vec_addr_o),
		.vec_rd_o(vec_rd_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
		.cpu_clk_en_o(cpu_clk_en_o), .osc_stop_o(osc_stop_o),
		.pins_oe_n_o(pins_oe_n_o), .periph_rst_o(periph_rst_o),
		.mem_hold_o(mem_hold_o), .resume_next_o(resume_next_o),
		.irq_service_o(irq_service_o), .psw_o(psw_o),
		.port_latch_o(port_latch_o), .port_dir_o(port_dir_o),
		.settle_sel_o(settle_sel_o), .irq_req_o(irq_req_o),
		.irq_mask_o(irq_mask_o), .edge_mode_o(edge_mode_o),
		.tx_shift_o(tx_shift_o));
	srs_partner #(.N_IRQ(8), .OSC_START(OSC_START), .VEC_WORD(VEC_WORD))
		u_srs_partner (.clk_sys_i(clk_sys_i), .osc_stop_i(osc_stop_o),
		.vec_addr_i(vec_addr_o), .vec_rd_i(vec_rd_o),
		.reset_pin_n_o(reset_pin_n_i), .wdt_ovf_o(wdt_ovf_i),
		.osc_run_o(osc_run_i), .irq_flag_o(irq_flag_i),
		.vec_data_o(vec_data_i));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
	begin
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask : check
	task automatic tick;
	begin
		@(posedge clk_sys_i);
		#2;
	end
	endtask : tick
	function automatic logic [15:0] win(input int lo, input int hi);
		return {15'h0, n_cyc >= lo && n_cyc <= hi};
	endfunction : win
	// counts cycles until the cpu runs, plus pulses seen on the way
	task automatic wait_run(input int max);
	begin
		n_cyc = 0;
		n_srv = 0;
		n_nxt = 0;
		n_pcl = 0;
		n_drv = 0;
		n_rst = 0;
		repeat (4) if (cpu_clk_en_o === 1'b1) tick();
		while (cpu_clk_en_o !== 1'b1 && n_cyc < max)
		begin
			tick();
			n_cyc++;
			n_drv += int'(pins_oe_n_o !== 1'b1 && cpu_clk_en_o !== 1'b1);
			n_rst += int'(periph_rst_o === 1'b1 || pins_oe_n_o === 1'b1);
			n_srv += int'(irq_service_o === 1'b1);
			n_nxt += int'(resume_next_o === 1'b1);
			n_pcl += int'(pc_load_o === 1'b1);
		end
		repeat (2)
		begin
			tick();
			n_srv += int'(irq_service_o === 1'b1);
			n_nxt += int'(resume_next_o === 1'b1);
			n_pcl += int'(pc_load_o === 1'b1);
		end
	end
	endtask : wait_run
	task automatic check_boot;
	begin
		check("pc", pc_o, VEC_WORD);
		check("pc loads", 16'(n_pcl), 16'h0001);
		check("pins early", 16'(n_drv), 16'h0000);
		check("pins oe_n", {15'h0, pins_oe_n_o}, 16'h0000);
		check("periph rst", {15'h0, periph_rst_o}, 16'h0000);
	end
	endtask : check_boot
	task automatic do_stop;
	begin
		stop_cmd_i = 1'b1;
		tick();
		stop_cmd_i = 1'b0;
		repeat (3) tick();
	end
	endtask : do_stop
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_powerup;
	begin
		check("oe held", {15'h0, pins_oe_n_o}, 16'h0001);
		check("periph held", {15'h0, periph_rst_o}, 16'h0001);
		check("cpu gated", {15'h0, cpu_clk_en_o}, 16'h0000);
		check("no hold", {15'h0, mem_hold_o}, 16'h0000);
		check("psw", 16'(psw_o), 16'h0002);
		check("latch", 16'(port_latch_o), 16'h0000);
		check("dir", 16'(port_dir_o), 16'h00FF);
		check("settle sel", 16'(settle_sel_o), 16'h0004);
		check("req", 16'(irq_req_o), 16'h0000);
		check("mask", 16'(irq_mask_o), 16'h00FF);
		check("edge", 16'(edge_mode_o), 16'h0000);
		check("tx shift", 16'(tx_shift_o), 16'h00FF);
		rst_i = 1'b0;
		wait_run(LIM15 + 200);
		check("reset settle", win(LIM15, LIM15 + 8), 16'h0001);
		check_boot();
		$display("test powerup done");
	end
	endtask : t_powerup
	task automatic t_wake(input logic en);
	begin
		accept_en_i = en;
		u_srs_partner.set_flags(8'h01);
		do_stop();
		repeat (50) tick();
		check("masked", {15'h0, cpu_clk_en_o}, 16'h0000);
		check("osc off", {15'h0, osc_stop_o}, 16'h0001);
		irq_mask_i = 8'hFE;
		wait_run(LIM12 + 200);
		check("wake", win(LIM12 + OSC_START, LIM12 + 28), 16'h1);
		check("service", 16'(n_srv), {15'h0, en});
		check("resume", 16'(n_nxt), {15'h0, ~en});
		check("no load", 16'(n_pcl), 16'h0000);
		check("wake keeps state", 16'(n_rst), 16'h0000);
		irq_mask_i = 8'hFF;
		u_srs_partner.set_flags(8'h00);
		$display("test wake done");
	end
	endtask : t_wake
	task automatic t_wdt;
	begin
		u_srs_partner.wdt_pulse();
		wait_run(LIM12 + 200);
		check("wdt settle", win(LIM12, LIM12 + 8), 16'h0001);
		check_boot();
		$display("test watchdog done");
	end
	endtask : t_wdt
	task automatic t_pin_stop;
	begin
		do_stop();
		u_srs_partner.pin_reset(SRS_PIN_LOW_CYC);
		check("stop pins", {15'h0, pins_oe_n_o}, 16'h0001);
		check("stop held", {15'h0, osc_stop_o}, 16'h0001);
		check("mem hold", {15'h0, mem_hold_o}, 16'h0001);
		wait_run(LIM15 + 200);
		check("pin", win(LIM15 + OSC_START, LIM15 + 30), 16'h1);
		check_boot();
		$display("test pin reset in stop done");
	end
	endtask : t_pin_stop
	task automatic tally_and_finish;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask : tally_and_finish
	initial
	begin
		#(95000 * 25);
		num_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial
	begin
		repeat (6) tick();
		t_powerup();
		t_wake(1'b1);
		t_wake(1'b0);
		t_wdt();
		t_pin_stop();
		tally_and_finish();
	end
endmodule : srs_sequencer_tb
